// >>> logic/dbrt_pkg.sv
/*
  Shared constants, types and decode helpers for the dual-button reset timer.
  Assumes a single 50 MHz clock and a 1 us internal time base derived from it.
*/
package dbrt_pkg;

  // ==========================================================================
  // Clock and time base
  localparam int unsigned CLOCK_MHZ        = 50;
  localparam int unsigned TICK_US          = 1;
  localparam int unsigned TICK_CYCLES_DEF  = CLOCK_MHZ * TICK_US;
  localparam int unsigned PRE_W            = 16;

  // ==========================================================================
  // Documented times in their own units
  localparam int unsigned HOLD_TIME_MS     = 7500;
  localparam int unsigned PULSE_LONG_MS    = 400;
  localparam int unsigned PULSE_SHORT_MS   = 80;
  localparam int unsigned DETECT_TIME_US   = 150;
  localparam int unsigned STARTUP_TIME_US  = 150;

  // ==========================================================================
  // Derived counts of time-base ticks
  localparam int unsigned HOLD_TICKS_DEF        = HOLD_TIME_MS * 1000 / TICK_US;
  localparam int unsigned PULSE_LONG_TICKS_DEF  = PULSE_LONG_MS * 1000 / TICK_US;
  localparam int unsigned PULSE_SHORT_TICKS_DEF = PULSE_SHORT_MS * 1000 / TICK_US;
  localparam int unsigned DETECT_TICKS_DEF      = DETECT_TIME_US / TICK_US;
  localparam int unsigned STARTUP_TICKS_DEF     = STARTUP_TIME_US / TICK_US;
  localparam int unsigned CNT_W                 = 24;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_START,
    ST_IDLE,
    ST_HOLD,
    ST_PULSE,
    ST_WAIT
  } dbrt_fsm_type;

  typedef struct packed {
    logic a_n;
    logic b_n;
  } dbrt_buttons_type;

  typedef struct packed {
    logic out;
    logic oe;
  } dbrt_od_pin_type;

  typedef struct packed {
    dbrt_fsm_type     fsm;
    logic [CNT_W-1:0] count;
    logic             strap_long;
    logic             drive;
  } dbrt_state_type;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
  } dbrt_tick_state_type;

  // ==========================================================================
  // Decode
  function automatic logic dbrt_both_low(input dbrt_buttons_type b);
    dbrt_both_low = !b.a_n && !b.b_n;
  endfunction : dbrt_both_low

endpackage : dbrt_pkg

// >>> logic/dbrt_reset_timer.sv
/*
  Dual push-button reset timer: two active-low buttons held together long
  enough give one fixed-length low pulse on an open-drain reset pin.
  Assumes synchronous, debounced inputs and an external pull-up on the pin.
  i_rst stands for the power-on reset; the strap is caught after its release.
*/
`timescale 1ns/1ps
module dbrt_reset_timer
  import dbrt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES       = TICK_CYCLES_DEF,
  parameter int unsigned HOLD_TICKS        = HOLD_TICKS_DEF,
  parameter int unsigned DETECT_TICKS      = DETECT_TICKS_DEF,
  parameter int unsigned STARTUP_TICKS     = STARTUP_TICKS_DEF,
  parameter int unsigned PULSE_LONG_TICKS  = PULSE_LONG_TICKS_DEF,
  parameter int unsigned PULSE_SHORT_TICKS = PULSE_SHORT_TICKS_DEF,
  parameter bit          LONG_PULSE        = 1'b1
)(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_enable,
  input  wire dbrt_buttons_type i_buttons,
  input  wire logic             i_hold_time_select,
  input  wire logic             i_reset_line,
  output dbrt_od_pin_type       o_reset_pin
);

  // ==========================================================================
  // Checks and derived counts
  localparam int unsigned PULSE_TICKS = LONG_PULSE ? PULSE_LONG_TICKS : PULSE_SHORT_TICKS;

  if (HOLD_TICKS < 1 || DETECT_TICKS < 1 || STARTUP_TICKS < 1 || PULSE_TICKS < 1 ||
      HOLD_TICKS >= (1 << CNT_W) || PULSE_TICKS >= (1 << CNT_W) ||
      DETECT_TICKS >= (1 << CNT_W) || STARTUP_TICKS >= (1 << CNT_W))
  begin : g_bad_counts
    $error("dbrt_reset_timer: tick counts out of range");
  end

  localparam logic [CNT_W-1:0] HOLD_LAST    = CNT_W'(HOLD_TICKS - 1);
  localparam logic [CNT_W-1:0] DETECT_LAST  = CNT_W'(DETECT_TICKS - 1);
  localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_TICKS - 1);
  localparam logic [CNT_W-1:0] PULSE_LAST   = CNT_W'(PULSE_TICKS - 1);

  dbrt_state_type s_ff;
  dbrt_state_type nxt_s;
  logic           both_low;
  logic           tick;
  logic           tick_clear;
  logic [CNT_W-1:0] hold_last;

  assign both_low  = dbrt_both_low(i_buttons);
  assign hold_last = s_ff.strap_long ? HOLD_LAST : DETECT_LAST;

  // ==========================================================================
  // Time base
  // Restarting the phase on release makes the hold exact to the cycle
  assign tick_clear = !both_low && (s_ff.fsm != ST_PULSE) && (s_ff.fsm != ST_START);

  dbrt_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_enable (i_enable),
    .i_clear  (tick_clear),
    .o_tick   (tick)
  );

  // ==========================================================================
  // Sequencer
  always_comb
  begin
    nxt_s = s_ff;
    if (i_enable)
    begin
      unique case (s_ff.fsm)
        ST_START:
        begin
          // Strap low selects the long hold; frozen once start-up ends
          nxt_s.strap_long = !i_hold_time_select;
          if (tick)
          begin
            if (s_ff.count == STARTUP_LAST)
            begin
              nxt_s.fsm   = ST_IDLE;
              nxt_s.count = '0;
            end
            else
              nxt_s.count = s_ff.count + 1'b1;
          end
        end
        ST_IDLE:
        begin
          if (both_low)
          begin
            nxt_s.fsm   = ST_HOLD;
            nxt_s.count = '0;
          end
        end
        ST_HOLD:
        begin
          if (!both_low)
            nxt_s.fsm = ST_IDLE;
          else if (tick)
          begin
            if (s_ff.count == hold_last)
            begin
              nxt_s.fsm   = ST_PULSE;
              nxt_s.count = '0;
              nxt_s.drive = 1'b1;
            end
            else
              nxt_s.count = s_ff.count + 1'b1;
          end
        end
        ST_PULSE:
        begin
          // Buttons not looked at: the pulse always runs out
          if (tick)
          begin
            if (s_ff.count == PULSE_LAST)
            begin
              nxt_s.fsm   = ST_WAIT;
              nxt_s.count = '0;
              nxt_s.drive = 1'b0;
            end
            else
              nxt_s.count = s_ff.count + 1'b1;
          end
        end
        ST_WAIT:
        begin
          if (!both_low)
            nxt_s.fsm = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_ff            <= '0;
      s_ff.fsm        <= ST_START;
      s_ff.strap_long <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  // ==========================================================================
  // Open-drain pin
  // Only ever pulls low; the pull-up gives the high level
  assign o_reset_pin.out = 1'b0;
  assign o_reset_pin.oe  = s_ff.drive;

  // ==========================================================================
  // Assertion helpers
  localparam int unsigned HOLD_CYC    = HOLD_TICKS * TICK_CYCLES;
  localparam int unsigned DETECT_CYC  = DETECT_TICKS * TICK_CYCLES;
  localparam int unsigned PULSE_CYC   = PULSE_TICKS * TICK_CYCLES;
  localparam int unsigned BOOT_CYC    = (STARTUP_TICKS + DETECT_TICKS) * TICK_CYCLES;

  logic [31:0] low_run_ff;
  logic [31:0] oe_run_ff;
  logic [31:0] since_rst_ff;
  logic        rearmed_ff;
  logic [31:0] thr_cyc;

  assign thr_cyc = s_ff.strap_long ? HOLD_CYC : DETECT_CYC;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      low_run_ff   <= '0;
      oe_run_ff    <= '0;
      since_rst_ff <= '0;
      rearmed_ff   <= 1'b1;
    end
    else if (i_enable)
    begin
      low_run_ff   <= !both_low ? '0 : (&low_run_ff ? low_run_ff : low_run_ff + 1'b1);
      oe_run_ff    <= !o_reset_pin.oe ? '0 : oe_run_ff + 1'b1;
      since_rst_ff <= &since_rst_ff ? since_rst_ff : since_rst_ff + 1'b1;
      if (!both_low)
        rearmed_ff <= 1'b1;
      else if (o_reset_pin.oe)
        rearmed_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_pulse_start;
    $rose(o_reset_pin.oe);
  endsequence

  sequence s_pulse_end;
    $fell(o_reset_pin.oe);
  endsequence

  sequence s_release_in_hold;
    i_enable && s_ff.fsm == ST_HOLD && !both_low;
  endsequence

  property p_hold_met;
    s_pulse_start |-> low_run_ff >= thr_cyc;
  endproperty
  a_hold_met: assert property (p_hold_met) else $error("Pulse before hold time");

  property p_release_aborts;
    s_release_in_hold |=> s_ff.fsm == ST_IDLE ##1 !o_reset_pin.oe;
  endproperty
  a_release_aborts: assert property (p_release_aborts) else $error("Release did not stop timer");

  property p_pin_matches_state;
    !o_reset_pin.out && (o_reset_pin.oe == (s_ff.fsm == ST_PULSE));
  endproperty
  a_pin_matches_state: assert property (p_pin_matches_state) else $error("Pin drive wrong");

  property p_zero_hold;
    i_enable && !s_ff.strap_long && s_ff.fsm == ST_HOLD && both_low && low_run_ff == DETECT_CYC - 1
      |=> o_reset_pin.oe;
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("Detection delay missed");

  property p_pulse_len;
    s_pulse_end |-> $past(oe_run_ff) == PULSE_CYC - 1;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("Pulse length wrong");

  property p_pulse_holds;
    o_reset_pin.oe && oe_run_ff < PULSE_CYC - 1 |=> o_reset_pin.oe;
  endproperty
  a_pulse_holds: assert property (p_pulse_holds) else $error("Pulse cut short");

  property p_boot_delay;
    s_pulse_start |-> since_rst_ff >= BOOT_CYC;
  endproperty
  a_boot_delay: assert property (p_boot_delay) else $error("Pulse too soon after power-up");

  property p_one_pulse;
    s_pulse_start |-> rearmed_ff;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("Pulse without rearm");

  property p_no_retrigger;
    s_pulse_end ##0 both_low |=> !o_reset_pin.oe;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) else $error("Second pulse on same hold");

  property p_strap_frozen;
    s_ff.fsm != ST_START |=> $stable(s_ff.strap_long);
  endproperty
  a_strap_frozen: assert property (p_strap_frozen) else $error("Strap changed after power-up");

  property p_count_on_tick;
    i_enable && s_ff.fsm == ST_HOLD && both_low && !tick |=> $stable(s_ff.count);
  endproperty
  a_count_on_tick: assert property (p_count_on_tick) else $error("Count moved without tick");

  property p_line_low;
    o_reset_pin.oe |-> !i_reset_line;
  endproperty
  a_line_low: assert property (p_line_low) else $error("Reset line not low while driven");

endmodule : dbrt_reset_timer

// >>> logic/dbrt_tick.sv
/*
  Internal time base: one-cycle tick every TICK_CYCLES enabled clocks.
  Assumes i_clear restarts the phase so a tick lands exactly TICK_CYCLES after it.
*/
`timescale 1ns/1ps
module dbrt_tick
  import dbrt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)(
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_enable,
  input  wire logic i_clear,
  output logic      o_tick
);

  // ==========================================================================
  // Checks
  if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << PRE_W))
  begin : g_bad_tick
    $error("dbrt_tick: TICK_CYCLES out of range");
  end

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  dbrt_tick_state_type s_ff;
  dbrt_tick_state_type nxt_s;

  // ==========================================================================
  // Prescaler
  always_comb
  begin
    nxt_s = s_ff;
    if (i_enable)
    begin
      if (i_clear || s_ff.pre == PRE_LAST)
        nxt_s.pre = '0;
      else
        nxt_s.pre = s_ff.pre + 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  // Strobe, suppressed while the phase is being restarted
  assign o_tick = i_enable && !i_clear && (s_ff.pre == PRE_LAST);

endmodule : dbrt_tick

// >>> verification/dbrt_far_side.sv
/*
  Far-side model: two push buttons and the pulled-up system reset net.
  Assumes the bench changes its press commands just after a rising edge.
*/
`timescale 1ns/1ps
module dbrt_far_side
  import dbrt_pkg::*;
(
  input  wire logic            i_press_a,
  input  wire logic            i_press_b,
  input  wire logic            i_tie_b,
  input  wire dbrt_od_pin_type i_reset_pin,
  output dbrt_buttons_type     o_buttons,
  output logic                 o_reset_line
);
  // ==========================================================================
  // Buttons, pressed pulls low
  assign o_buttons.a_n = ~i_press_a;
  assign o_buttons.b_n = ~(i_press_b | i_tie_b);

  // ==========================================================================
  // Reset net, pull-up wins when released
  assign o_reset_line = i_reset_pin.oe ? 1'b0 : 1'b1;
endmodule : dbrt_far_side

// >>> verification/dbrt_reset_timer_bench.sv
/*
  Scenario bench for the reset timer, with shortened counts.
  Assumes dbrt_far_side resolves the buttons and the reset net.
*/
`timescale 1ns/1ps
module dbrt_reset_timer_bench
  import dbrt_pkg::*;
;
  localparam int TC = 2;
  localparam int HT = 20;
  localparam int DT = 3;
  localparam int ST = 3;
  localparam int PL = 10;
  localparam int PS = 4;
  logic             i_clock;
  logic             i_rst;
  logic             i_enable;
  logic             strap;
  logic             pa;
  logic             pb;
  logic             tie_b;
  logic             line;
  dbrt_buttons_type btn;
  dbrt_od_pin_type  pin;
  dbrt_od_pin_type  pin_s;
  int               error_cnt;
  int               checked;
  int               cyc;
  int               n;

  // ==========================================================================
  // Design and far side
  dbrt_reset_timer #(.TICK_CYCLES(TC), .HOLD_TICKS(HT), .DETECT_TICKS(DT), .STARTUP_TICKS(ST),
    .PULSE_LONG_TICKS(PL), .PULSE_SHORT_TICKS(PS), .LONG_PULSE(1'b1)) u_dut (.i_clock(i_clock),
    .i_rst(i_rst), .i_enable(i_enable), .i_buttons(btn), .i_hold_time_select(strap),
    .i_reset_line(line), .o_reset_pin(pin));
  // Short variant on its own net so it never sees the long pulse
  dbrt_reset_timer #(.TICK_CYCLES(TC), .HOLD_TICKS(HT), .DETECT_TICKS(DT), .STARTUP_TICKS(ST),
    .PULSE_LONG_TICKS(PL), .PULSE_SHORT_TICKS(PS), .LONG_PULSE(1'b0)) u_dut_short (.i_clock(i_clock),
    .i_rst(i_rst), .i_enable(i_enable), .i_buttons(btn), .i_hold_time_select(strap),
    .i_reset_line(~pin_s.oe), .o_reset_pin(pin_s));
  dbrt_far_side u_far (.i_press_a(pa), .i_press_b(pb), .i_tie_b(tie_b), .i_reset_pin(pin),
    .o_buttons(btn), .o_reset_line(line));

  // ==========================================================================
  // Helpers
  task automatic wrap_up;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi)
    begin
      error_cnt++;
      $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : check_rng

  task automatic check_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic tick(input int k);
    repeat (k) @(posedge i_clock);
    #1;
  endtask : tick

  // Edges until the net reaches lvl, bounded
  task automatic wait_line(input logic lvl);
    n = 0;
    while (line !== lvl && n < 400)
    begin
      tick(1);
      n++;
    end
  endtask : wait_line

  task automatic press(input logic a, input logic b);
    pa = a;
    pb = b;
  endtask : press

  task automatic power_up(input logic s, input logic p);
    i_rst = 1'b1;
    strap = s; // Strap set while powered down; sc_zero moves it again after start-up
    press(p, p);
    tick(3);
    check_bit("line_in_reset", 1'b1, line);
    i_rst = 1'b0;
  endtask : power_up

  // ==========================================================================
  // Scenarios
  task automatic sc_long;
    int nl;
    int ns;
    power_up(1'b0, 1'b0); // Normal ground strap
    tick(ST * TC + 4);
    press(1'b1, 1'b1);
    wait_line(1'b0);
    check_rng("hold_long", HT * TC, HT * TC, n);
    check_bit("pin_out", 1'b0, pin.out);
    nl = 0;
    ns = 0;
    repeat (PL * TC + 4)
    begin
      nl += pin.oe;
      ns += pin_s.oe;
      tick(1);
    end
    check_rng("pulse_long", PL * TC, PL * TC, nl);
    check_rng("pulse_short", PS * TC, PS * TC, ns);
    tick(HT * TC + 10);
    check_bit("no_repeat", 1'b1, line);
    pb = 1'b0;
    tick(1);
    pb = 1'b1;
    wait_line(1'b0);
    check_rng("rearm", HT * TC, HT * TC, n);
    press(1'b0, 1'b0);
    tick(PL * TC - 1);
    check_bit("pulse_tail", 1'b0, line);
    tick(1);
    check_bit("pulse_end", 1'b1, line);
  endtask : sc_long

  task automatic sc_abort;
    tick(1); // Post-pulse wait must see the release before a new hold
    press(1'b1, 1'b1);
    tick(HT * TC - 2);
    pb = 1'b0;
    tick(1);
    pb = 1'b1;
    wait_line(1'b0);
    check_rng("restart", HT * TC, HT * TC, n);
    press(1'b1, 1'b0);
    tick(PL * TC + HT * TC + 10);
    check_bit("one_button", 1'b1, line);
    pb = 1'b1;
    tick(5);
    i_enable = 1'b0;
    tick(6);
    i_enable = 1'b1;
    wait_line(1'b0);
    check_rng("enable_stall", HT * TC - 5, HT * TC - 5, n);
    press(1'b0, 1'b0);
    tie_b = 1'b1;
    tick(PL * TC + 2);
    pa = 1'b1;
    wait_line(1'b0);
    check_rng("single_channel", HT * TC, HT * TC, n);
    pa = 1'b0;
    tie_b = 1'b0;
    tick(PL * TC + 2);
  endtask : sc_abort

  task automatic sc_zero;
    power_up(1'b1, 1'b0);
    tick(ST * TC + 4);
    press(1'b1, 1'b1);
    wait_line(1'b0);
    check_rng("detect", DT * TC, DT * TC, n);
    press(1'b0, 1'b0);
    tick(PL * TC + 2);
    strap = 1'b0;
    press(1'b1, 1'b1);
    wait_line(1'b0);
    check_rng("strap_kept", DT * TC, DT * TC, n);
    press(1'b0, 1'b0);
    tick(PL * TC + 2);
    power_up(1'b1, 1'b1);
    wait_line(1'b0);
    check_rng("startup_detect", (ST + DT) * TC, (ST + DT) * TC + 2, n);
    press(1'b0, 1'b0);
    tick(PL * TC + 2);
  endtask : sc_zero

  // ==========================================================================
  // Clock, timeout, main sequence
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  initial
  begin
    i_rst = 1'b1;
    i_enable = 1'b1;
    strap = 1'b0;
    tie_b = 1'b0;
    press(1'b0, 1'b0);
    tick(9); // Power-up task holds reset three more cycles
    sc_long();
    sc_abort();
    sc_zero();
    wrap_up();
  end
endmodule : dbrt_reset_timer_bench
